// >>> logic/smi_consts.svh
// Constants of the sensor I2C target frame engine
`ifndef SMI_CONSTS_SVH
`define SMI_CONSTS_SVH
`define SMI_GCALL_ADDR 8'h00
`define SMI_FRAME_16 2'h1
`define SMI_FRAME_8 2'h2
`define SMI_STD_CRC_POS 3'h4
`define SMI_SLOT_STATUS 8
`define SMI_SLOT_CRC 9
`define SMI_SLOT_END 4'ha
`define SMI_IDLE_BYTE 8'hff
`define SMI_CRC_POLY 8'h07
`define SMI_CRC_INIT 8'hff
`define SMI_BYTE_BITS 4'h8
`endif

// >>> logic/smi_pkg.sv
// Types of the sensor I2C target frame engine
package smi_pkg;
  typedef enum logic [2:0] {
    SMI_IDLE, SMI_ADDR, SMI_ADDR_ACK, SMI_WR_BYTE, SMI_WR_ACK,
    SMI_RD_BYTE, SMI_RD_ACK, SMI_IGNORE
  } smi_state_type;
endpackage

// >>> logic/smi_crc_if.sv
// Link between the frame engine and its CRC generator
`timescale 1ns/10ps
interface smi_crc_if;
  logic clear;
  logic feed;
  logic [7:0] data;
  logic [7:0] crc;
  modport user (output clear, output feed, output data, input crc);
  modport engine (input clear, input feed, input data, output crc);
endinterface

// >>> logic/smi_crc.sv
// Byte-wide CRC-8 generator with clear and feed strobes
`timescale 1ns/10ps
`include "smi_consts.svh"
module smi_crc #(
  parameter logic [7:0] POLY = `SMI_CRC_POLY,
  parameter logic [7:0] INIT = `SMI_CRC_INIT
) (
  input wire logic clk,
  input wire logic rst,
  smi_crc_if.engine bus
);
  logic [7:0] crc;
  logic [7:0] next_crc;
  wire [7:0] seed = bus.clear ? INIT : crc;

  // Clear and feed together restart the sum with the fed byte
  always_comb begin
    next_crc = seed ^ bus.data;
    for (int i = 0; i < 8; i++) begin
      next_crc = next_crc[7] ? ({next_crc[6:0], 1'b0} ^ POLY) : {next_crc[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) crc <= INIT;
    else if (bus.feed) crc <= next_crc;
    else if (bus.clear) crc <= INIT;
  end

  assign bus.crc = crc;
endmodule // smi_crc

// >>> logic/smi_target.sv
// I2C target frame engine: writes, standard reads and compact one-byte read frames
// What this block does
// R1: An addressed write opens with the 7-bit target address and a read/write bit of 0.
// R2: A 1 in the top bit of the pointer byte starts a conversion once the pointer byte is received.
// R3: The low seven bits of the pointer byte become the starting register address.
// R4: Each written data byte goes to the current address, which then steps by one.
// R5: A general call with an all-zero first byte is handled exactly like an addressed write.
// R6: A standard read returns register data from the pointer, stepping per controller ACK.
// R7: With CRC on, a standard read sends a CRC over the last four register bytes as fifth byte.
// R8: Frame selector 01b sends 16 bits of each enabled channel, then the status byte.
// R9: Frame selector 10b sends the upper 8 bits of each enabled channel, then the status byte.
// R10: A one-byte read frame carries only the address with read/write at 1, no pointer byte.
// R11: Enabled channels go out in the order temperature, X, Y, Z.
// R12: With CRC on, a frame ends with a CRC over the command byte and all its data bytes.
// R13: Only the own address or the general call is acknowledged; others leave SDA released.
// R14: CRC polynomial and initial value are parameters to be confirmed for the product.
`timescale 1ns/10ps
`include "smi_consts.svh"
module smi_target #(
  parameter logic [7:0] CRC_POLY = `SMI_CRC_POLY, // R14
  parameter logic [7:0] CRC_INIT = `SMI_CRC_INIT // R14
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [6:0] own_address,
  input wire logic [1:0] read_frame_sel,
  input wire logic crc_enable,
  input wire logic [2:0] magnetic_channel_enable,
  input wire logic temperature_channel_enable,
  input wire logic [15:0] temp_result,
  input wire logic [15:0] x_result,
  input wire logic [15:0] y_result,
  input wire logic [15:0] z_result,
  input wire logic [7:0] conv_status,
  input wire logic [7:0] reg_rdata,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic conv_trigger,
  output logic addressed
);
  smi_pkg::smi_state_type st;
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic [3:0] bitcnt;
  logic [7:0] shreg, tx;
  logic is_read, ack_ok, first_byte, last_reg;
  logic [6:0] ptr;
  logic [2:0] rd_cnt;
  logic [3:0] slot_ptr, pick;
  // Nets, since every slot and channel is driven by its own assignment
  wire [9:0] slot_ok;
  wire [7:0] slot_data [10];
  wire [15:0] chan [4];
  logic [3:0] chan_en;
  smi_crc_if crc_bus ();

  smi_crc #(.POLY(CRC_POLY), .INIT(CRC_INIT)) u_crc (
    .clk(clk),
    .rst(rst),
    .bus(crc_bus)
  );

  // Pins cross two flops; edges are only judged on the settled copies
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
    end
  end

  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire start_c = scl_s && scl_d && sda_d && !sda_s;
  wire stop_c = scl_s && scl_d && !sda_d && sda_s;
  wire rx_state = (st == smi_pkg::SMI_ADDR) || (st == smi_pkg::SMI_WR_BYTE);
  wire rx_end = rx_state && scl_fall && (bitcnt == `SMI_BYTE_BITS);
  wire gcall = shreg == `SMI_GCALL_ADDR;
  wire addr_hit = (shreg[7:1] == own_address) || gcall; // R13 R5
  wire adr_end = (st == smi_pkg::SMI_ADDR) && rx_end;
  wire rd_go = adr_end && addr_hit && shreg[0]; // R10
  wire wr_end = (st == smi_pkg::SMI_WR_BYTE) && rx_end;
  wire rd_ack = (st == smi_pkg::SMI_RD_ACK) && scl_rise && !sda_s;
  wire load = scl_fall && (((st == smi_pkg::SMI_ADDR_ACK) && is_read) ||
                           ((st == smi_pkg::SMI_RD_ACK) && ack_ok));
  wire sixteen = read_frame_sel == `SMI_FRAME_16;
  wire frame_mode = sixteen || (read_frame_sel == `SMI_FRAME_8);
  wire std_crc_now = crc_enable && (rd_cnt == `SMI_STD_CRC_POS); // R7

  // Frame slots: T hi/lo, X hi/lo, Y hi/lo, Z hi/lo, status, CRC
  assign chan[0] = temp_result;
  assign chan[1] = x_result;
  assign chan[2] = y_result;
  assign chan[3] = z_result;
  assign chan_en = {magnetic_channel_enable, temperature_channel_enable};
  for (genvar g = 0; g < 10; g++) begin : g_slot
    if (g < `SMI_SLOT_STATUS) begin : g_chan
      assign slot_ok[g] = chan_en[g / 2] && ((g % 2 == 0) || sixteen); // R8 R9
      assign slot_data[g] = (g % 2 == 1) ? chan[g / 2][7:0] : chan[g / 2][15:8];
    end else if (g == `SMI_SLOT_STATUS) begin : g_stat
      assign slot_ok[g] = 1'b1;
      assign slot_data[g] = conv_status;
    end else begin : g_crc
      assign slot_ok[g] = crc_enable; // R12
      assign slot_data[g] = crc_bus.crc;
    end
  end

  // Only slots at or after the pointer remain, so the order is fixed
  wire [9:0] avail = slot_ok & ~((10'h1 << slot_ptr) - 10'h1); // R11
  wire pick_valid = |avail;
  always_comb begin
    pick = 4'h0;
    for (int i = 9; i >= 0; i--) begin
      if (avail[i]) pick = 4'(i);
    end
  end
  wire pick_crc = pick == 4'(`SMI_SLOT_CRC);
  wire [7:0] frame_byte = pick_valid ? slot_data[pick] : `SMI_IDLE_BYTE;
  wire [7:0] std_byte = std_crc_now ? crc_bus.crc : reg_rdata; // R6 R7
  wire [7:0] load_byte = frame_mode ? frame_byte : std_byte;
  wire crc_byte = frame_mode ? pick_crc : std_crc_now;

  // The CRC starts at the read address; a frame also sums the command byte
  assign crc_bus.clear = rd_go || (load && crc_byte);
  assign crc_bus.feed = (rd_go && frame_mode) ||
                        (load && !crc_byte && (pick_valid || !frame_mode)); // R12 R7
  assign crc_bus.data = rd_go ? shreg : load_byte;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= smi_pkg::SMI_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      sda_oe_n <= 1'b1;
      is_read <= 1'b0;
      ack_ok <= 1'b0;
      addressed <= 1'b0;
    end else if (start_c) begin
      st <= smi_pkg::SMI_ADDR;
      bitcnt <= 4'h0;
      sda_oe_n <= 1'b1;
      addressed <= 1'b0;
    end else if (stop_c) begin
      st <= smi_pkg::SMI_IDLE;
      sda_oe_n <= 1'b1;
      addressed <= 1'b0;
    end else begin
      case (st)
        smi_pkg::SMI_ADDR, smi_pkg::SMI_WR_BYTE: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end else if (rx_end) begin
            bitcnt <= 4'h0;
            if (adr_end && !addr_hit) begin
              st <= smi_pkg::SMI_IGNORE; // R13
            end else begin
              sda_oe_n <= 1'b0;
              st <= adr_end ? smi_pkg::SMI_ADDR_ACK : smi_pkg::SMI_WR_ACK;
              if (adr_end) is_read <= shreg[0];
              if (adr_end) addressed <= 1'b1;
            end
          end
        end
        smi_pkg::SMI_ADDR_ACK, smi_pkg::SMI_WR_ACK, smi_pkg::SMI_RD_ACK: begin
          if (load) begin
            tx <= load_byte;
            sda_oe_n <= load_byte[7];
            bitcnt <= 4'h1;
            st <= smi_pkg::SMI_RD_BYTE;
          end else if (st == smi_pkg::SMI_RD_ACK) begin
            // A NACK ends our turn; the controller must follow with stop or start
            if (scl_rise && sda_s) st <= smi_pkg::SMI_IGNORE;
            else if (scl_rise) ack_ok <= 1'b1;
          end else if (scl_fall) begin
            sda_oe_n <= 1'b1;
            st <= smi_pkg::SMI_WR_BYTE;
          end
        end
        smi_pkg::SMI_RD_BYTE: begin
          if (scl_fall && (bitcnt == `SMI_BYTE_BITS)) begin
            sda_oe_n <= 1'b1;
            ack_ok <= 1'b0;
            st <= smi_pkg::SMI_RD_ACK;
          end else if (scl_fall) begin
            tx <= {tx[6:0], 1'b0};
            sda_oe_n <= tx[6];
            bitcnt <= bitcnt + 4'h1;
          end
        end
        smi_pkg::SMI_IGNORE: sda_oe_n <= 1'b1; // R13
        default: sda_oe_n <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr <= 7'h00;
      first_byte <= 1'b0;
      reg_addr <= 7'h00;
      reg_wdata <= 8'h00;
      reg_wr <= 1'b0;
      conv_trigger <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      reg_wr <= wr_end && !first_byte; // R4
      conv_trigger <= wr_end && first_byte && shreg[7]; // R2
      reg_addr <= ptr;
      if (adr_end && addr_hit && !shreg[0]) first_byte <= 1'b1; // R5
      if (wr_end && first_byte) begin
        ptr <= shreg[6:0]; // R3
        first_byte <= 1'b0;
      end else if (wr_end) begin
        reg_wdata <= shreg;
        ptr <= ptr + 7'h1; // R4
      end else if (rd_ack && last_reg) begin
        ptr <= ptr + 7'h1; // R6
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_cnt <= 3'h0;
      last_reg <= 1'b0;
      slot_ptr <= 4'h0;
    end else if (rd_go) begin
      rd_cnt <= 3'h0;
      slot_ptr <= 4'h0;
    end else if (load && frame_mode) begin
      slot_ptr <= pick_valid ? pick + 4'h1 : `SMI_SLOT_END; // R11
      last_reg <= 1'b0;
    end else if (load) begin
      rd_cnt <= std_crc_now ? 3'h0 : rd_cnt + 3'h1;
      last_reg <= !std_crc_now;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_ptr_byte;
    wr_end && first_byte;
  endsequence
  sequence s_data_byte;
    wr_end && !first_byte;
  endsequence

  property p_trig;
    s_ptr_byte |=> (conv_trigger == $past(shreg[7])) ##1 !conv_trigger;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger bit not honoured"); // R2
  property p_ptr;
    s_ptr_byte |=> ptr == $past(shreg[6:0]);
  endproperty
  a_ptr: assert property (p_ptr) else $error("start address not taken"); // R3
  property p_store;
    s_data_byte |=> reg_wr && reg_addr == $past(ptr) && reg_wdata == $past(shreg)
      && ptr == $past(ptr) + 7'h1;
  endproperty
  a_store: assert property (p_store) else $error("data byte store wrong"); // R4
  property p_gcall;
    adr_end && gcall |=> !sda_oe_n && st == smi_pkg::SMI_ADDR_ACK && first_byte;
  endproperty
  a_gcall: assert property (p_gcall) else $error("general call not taken"); // R5
  property p_rd_step;
    rd_ack && last_reg |=> ptr == $past(ptr) + 7'h1;
  endproperty
  a_rd_step: assert property (p_rd_step) else $error("read pointer did not step"); // R6
  property p_std_crc;
    load && !frame_mode && std_crc_now |=> tx == $past(crc_bus.crc) && rd_cnt == 3'h0;
  endproperty
  a_std_crc: assert property (p_std_crc) else $error("fifth byte is not CRC"); // R7
  property p_lo_next;
    load && frame_mode && sixteen && pick_valid && pick < 4'h8 && !pick[0]
      |=> slot_ptr == $past(pick) + 4'h1 && slot_ok[slot_ptr];
  endproperty
  a_lo_next: assert property (p_lo_next) else $error("low byte skipped"); // R8
  property p_hi_only;
    load && frame_mode && !sixteen && pick_valid |-> !pick[0] || pick > 4'h7;
  endproperty
  a_hi_only: assert property (p_hi_only) else $error("low byte in 8-bit frame"); // R9
  property p_order;
    load && frame_mode && pick_valid |-> pick >= slot_ptr;
  endproperty
  a_order: assert property (p_order) else $error("channel order broken"); // R11
  property p_frame_crc;
    load && frame_mode && pick_valid && pick_crc |=> tx == $past(crc_bus.crc);
  endproperty
  a_frame_crc: assert property (p_frame_crc) else $error("frame CRC wrong"); // R12
  property p_ignore;
    adr_end && !addr_hit |=> sda_oe_n [*2];
  endproperty
  a_ignore: assert property (p_ignore) else $error("foreign address answered"); // R13
endmodule // smi_target

// >>> dv/smi_ctl_model.sv
// Behavioural I2C controller that clocks SCL and drives SDA from the bench clock
`timescale 1ns/10ps
module smi_ctl_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_oe_n
);
  initial begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data moves only mid low phase, so the target never sees a false start or stop
  task automatic put_bit(input logic b, output logic r);
    tick(2);
    sda_oe_n <= b;
    tick(3);
    scl <= 1'b1;
    tick(4);
    r = sda;
    tick(1);
    scl <= 1'b0;
  endtask
  task automatic start();
    tick(2);
    sda_oe_n <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(5);
    sda_oe_n <= 1'b0;
    tick(5);
    scl <= 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sda_oe_n <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(5);
    sda_oe_n <= 1'b1;
    tick(5);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(d[i], r);
    put_bit(1'b1, r);
    ack = !r;
  endtask
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
    put_bit(!ack, r);
  endtask
endmodule // smi_ctl_model

// >>> dv/tb_smi_target.sv
// Self-checking bench of the I2C target frame engine
`timescale 1ns/10ps
module tb_smi_target;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wire logic sda;
  logic scl, ctl_oe_n, sda_out, dut_oe_n, reg_wr, conv_trigger, addressed;
  logic [6:0] own_address = 7'h2c;
  logic [1:0] read_frame_sel = 2'h0;
  logic crc_enable = 1'b0;
  logic [2:0] magnetic_channel_enable = 3'h0;
  logic temperature_channel_enable = 1'b0;
  logic [15:0] temp_result = 16'h1a2b;
  logic [15:0] x_result = 16'h3c4d;
  logic [15:0] y_result = 16'h5e6f;
  logic [15:0] z_result = 16'h7081;
  logic [7:0] conv_status = 8'h91;
  logic [7:0] reg_rdata, reg_wdata;
  logic [6:0] reg_addr;
  logic [14:0] wr_log [$];
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  int trig_count = 0;
  // Pull-up: the line is low while either party enables its driver
  assign sda = ctl_oe_n & dut_oe_n;
  assign reg_rdata = {1'b1, reg_addr};
  initial begin
    forever #4 clk = ~clk;
  end
  smi_target u_dut (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(dut_oe_n), .own_address(own_address), .read_frame_sel(read_frame_sel),
    .crc_enable(crc_enable), .magnetic_channel_enable(magnetic_channel_enable),
    .temperature_channel_enable(temperature_channel_enable), .temp_result(temp_result),
    .x_result(x_result), .y_result(y_result), .z_result(z_result),
    .conv_status(conv_status), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .conv_trigger(conv_trigger),
    .addressed(addressed));
  smi_ctl_model u_ctl (.clk(clk), .sda(sda), .scl(scl), .sda_oe_n(ctl_oe_n));
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (reg_wr) wr_log.push_back({reg_addr, reg_wdata});
    if (conv_trigger) trig_count <= trig_count + 1;
  end
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    wait (cycles == 20000);
    failures++;
    end_of_test();
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
    return r;
  endfunction
  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic ack;
    u_ctl.wr_byte(b, ack);
    chk("byte ack", 16'(exp_ack), 16'(ack));
  endtask
  // Last byte is refused by the controller so the target lets go before stop
  task automatic read_list(input logic [7:0] exp[$]);
    logic [7:0] d;
    for (int i = 0; i < exp.size(); i++) begin
      u_ctl.rd_byte(i < exp.size() - 1, d);
      chk("read byte", 16'(exp[i]), 16'(d));
    end
    u_ctl.stop();
    chk("addressed after stop", 16'h0000, 16'(addressed));
  endtask
  task automatic t_write(input logic [7:0] first, input logic [7:0] ptr, input logic hit);
    int t0;
    logic [6:0] a;
    t0 = trig_count;
    a = ptr[6:0];
    wr_log.delete();
    u_ctl.start();
    send(first, hit);
    chk("addressed", 16'(hit), 16'(addressed));
    send(ptr, hit);
    send(8'h3c, hit);
    send(8'ha7, hit);
    u_ctl.stop();
    chk("trigger pulses", 16'(hit & ptr[7]), 16'(trig_count - t0));
    chk("write count", hit ? 16'h0002 : 16'h0000, 16'(wr_log.size()));
    if (hit) begin
      chk("first write", {1'b0, a, 8'h3c}, {1'b0, wr_log[0]});
      chk("second write", {1'b0, a + 7'h01, 8'ha7}, {1'b0, wr_log[1]});
    end
  endtask
  // Selector 11 must behave as a standard read
  task automatic t_std_read(input logic [1:0] sel, input logic crc);
    logic [7:0] q[$];
    logic [7:0] c;
    @(posedge clk);
    read_frame_sel <= sel;
    crc_enable <= crc;
    c = 8'hff;
    for (int i = 0; i < 4; i++) begin
      q.push_back(8'h82 + 8'(i));
      c = crc8(c, q[i]);
    end
    if (crc) q.push_back(c);
    q.push_back(8'h86);
    u_ctl.start();
    send({own_address, 1'b0}, 1'b1);
    send(8'h02, 1'b1);
    u_ctl.start();
    send({own_address, 1'b1}, 1'b1);
    read_list(q);
  endtask
  task automatic t_frame(input logic [1:0] sel, input logic crc, input logic [3:0] en);
    logic [7:0] q[$];
    logic [15:0] ch[4];
    logic [7:0] c;
    @(posedge clk);
    read_frame_sel <= sel;
    crc_enable <= crc;
    temperature_channel_enable <= en[0];
    magnetic_channel_enable <= en[3:1];
    ch = '{temp_result, x_result, y_result, z_result};
    for (int i = 0; i < 4; i++) begin
      if (en[i]) begin
        q.push_back(ch[i][15:8]);
        if (sel == 2'h1) q.push_back(ch[i][7:0]);
      end
    end
    q.push_back(conv_status);
    c = crc8(8'hff, {own_address, 1'b1});
    foreach (q[i]) c = crc8(c, q[i]);
    if (crc) q.push_back(c);
    q.push_back(8'hff);
    u_ctl.start();
    send({own_address, 1'b1}, 1'b1);
    read_list(q);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk("released after reset", 16'h0001, 16'(dut_oe_n));
    chk("sda_out", 16'h0000, 16'(sda_out));
    t_write({own_address, 1'b0}, 8'h85, 1'b1);
    t_write({own_address, 1'b0}, 8'h21, 1'b1);
    t_write(8'h00, 8'h90, 1'b1);
    t_write({7'h13, 1'b0}, 8'h85, 1'b0);
    t_std_read(2'h0, 1'b1);
    t_std_read(2'h3, 1'b0);
    t_frame(2'h1, 1'b1, 4'hb);
    t_frame(2'h2, 1'b0, 4'hf);
    t_frame(2'h2, 1'b1, 4'h4);
    end_of_test();
  end
endmodule // tb_smi_target
